// ===== arm_pkg.sv
// constants for the alarm source, mask and latch block
// assumes a single ref_clk domain and an Avalon-MM register master
package arm_pkg;
	localparam int ARM_W = 16;
	localparam int ARM_AW = 4;
	// register byte offsets (word aligned)
	localparam logic [ARM_AW-1:0] ARM_OFF_RAW = 4'h0;
	localparam logic [ARM_AW-1:0] ARM_OFF_MASK = 4'h4;
	localparam logic [ARM_AW-1:0] ARM_OFF_LATCH = 4'h8;
	localparam logic [ARM_AW-1:0] ARM_OFF_CTRL = 4'hc;
	// source bit positions
	localparam int ARM_B_SAFETY_BC = 15;
	localparam int ARM_B_SAFETY_A = 14;
	localparam int ARM_B_PERMFAIL = 13;
	localparam int ARM_B_SF_ALERT = 12;
	localparam int ARM_B_PF_ALERT = 11;
	localparam int ARM_B_INIT_START = 10;
	localparam int ARM_B_INIT_DONE = 9;
	localparam int ARM_B_RESERVED = 8;
	localparam int ARM_B_FULL_LOOP = 7;
	localparam int ARM_B_CHG_OFF = 6;
	localparam int ARM_B_DSG_OFF = 5;
	localparam int ARM_B_STACK_LOW = 4;
	localparam int ARM_B_BLOW = 3;
	localparam int ARM_B_BALANCE = 2;
	localparam int ARM_B_SCAN = 1;
	localparam int ARM_B_WAKE = 0;
	// writable bits of the mask; bit 8 stays zero
	localparam logic [ARM_W-1:0] ARM_VALID_BITS = 16'hfeff;
	// control register: bit 0 reloads the mask from its stored default
	localparam int ARM_CTRL_RELOAD = 0;
	// busy cycles after reset before the bus answers (one settle cycle)
	localparam logic [1:0] ARM_SETTLE = 2'h1;
endpackage : arm_pkg

// ===== arm_alarm_core.sv
// alarm raw flags, latch mask and latched alarm with alert output
// assumes source detectors outside drive the level inputs synchronous to ref_clk
`timescale 1ns/1ns
module arm_alarm_core #(
	parameter logic [arm_pkg::ARM_W-1:0] DEFAULT_MASK = 16'h0000 // stored default alarm mask
) (
	input wire logic ref_clk, // system clock, 100 MHz
	input wire logic rst, // asynchronous reset, active high
	input wire logic clkEn, // low freezes all state
	input wire logic [arm_pkg::ARM_AW-1:0] address, // byte address
	input wire logic read, // avalon read
	input wire logic write, // avalon write
	input wire logic [3:0] byteenable, // avalon byte enables
	input wire logic [31:0] writedata, // avalon write data
	output logic [31:0] readdata, // avalon read data
	output logic waitrequest, // avalon stall
	output logic [1:0] response, // avalon response, 2'h2 on unmapped
	input wire logic safetyBcAny, // any bit in safety status B or C
	input wire logic safetyAAny, // any bit in safety status A
	input wire logic permFailFault, // enabled permanent fail fault triggered
	input wire logic safetyAlertHit, // safety alert and its alert mask bit
	input wire logic permFailAlertHit, // permanent fail alert and its mask bit
	input wire logic initStarted, // initialisation has begun
	input wire logic initCompleted, // initialisation done
	input wire logic fullLoopDone, // full measurement loop finished (pulse or level)
	input wire logic chargeSwitchOff, // charge switch is off
	input wire logic dischargeSwitchOff, // discharge switch is off
	input wire logic stackBelowShutdown, // stack below shutdown threshold
	input wire logic blowOutputDriven, // blow output driven by either party
	input wire logic balancingActive, // cell balancing active
	input wire logic singleScanDone, // single scan finished (pulse or level)
	input wire logic wokeFromSleep, // wake from sleep event
	output logic alert, // alert output, active high
	output logic [arm_pkg::ARM_W-1:0] latchedAlarm // latched alarm register view
);
	import arm_pkg::*;

	// the whole block state; one process fills the copy, one registers it
	typedef struct packed {
		logic [ARM_W-1:0] raw; // registered live flags
		logic [ARM_W-1:0] mask; // which raw flags may latch
		logic [ARM_W-1:0] latched; // write-one-to-clear alarm latch
		logic fullSeen; // first full loop already seen
		logic scanSeen; // first single scan already seen
		logic [1:0] settle; // bus blocked while nonzero
		logic [31:0] rdata; // read data of the last answer
		logic [1:0] resp; // response of the last answer
		logic busy; // answer cycle, waitrequest low
		logic alert; // registered alert level
		logic reloaded; // default mask taken after reset
	} arm_state_t;

	arm_state_t st;
	arm_state_t next_st;
	logic [ARM_W-1:0] srcNow; // live source flags, sticky ones included
	logic [ARM_W-1:0] clearBits; // bits written high to the latch this edge
	logic [ARM_W-1:0] setBits; // enabled sources asking to latch
	logic [ARM_W-1:0] latchNext; // latch contents after this edge
	logic [ARM_W-1:0] maskNext; // mask contents after this edge
	logic [31:0] readMux; // register picked by the address
	logic acc; // request taken at this edge
	logic hit; // address names a register
	logic commit; // held write lands at this edge
	logic reloadNow; // mask goes back to its stored default

	// one cell per alarm bit: route its source, then set, clear and hold the latch
	for (genvar i = 0; i < ARM_W; i++) begin : g_bit
		if (i == ARM_B_SAFETY_BC) begin : g_src
			assign srcNow[i] = safetyBcAny;
		end else if (i == ARM_B_SAFETY_A) begin : g_src
			assign srcNow[i] = safetyAAny;
		end else if (i == ARM_B_PERMFAIL) begin : g_src
			assign srcNow[i] = permFailFault;
		end else if (i == ARM_B_SF_ALERT) begin : g_src
			assign srcNow[i] = safetyAlertHit;
		end else if (i == ARM_B_PF_ALERT) begin : g_src
			assign srcNow[i] = permFailAlertHit;
		end else if (i == ARM_B_INIT_START) begin : g_src
			assign srcNow[i] = initStarted;
		end else if (i == ARM_B_INIT_DONE) begin : g_src
			assign srcNow[i] = initCompleted;
		end else if (i == ARM_B_FULL_LOOP) begin : g_src
			// a pulse from the loop sequencer is kept so the flag stays set
			assign srcNow[i] = fullLoopDone | st.fullSeen;
		end else if (i == ARM_B_CHG_OFF) begin : g_src
			assign srcNow[i] = chargeSwitchOff;
		end else if (i == ARM_B_DSG_OFF) begin : g_src
			assign srcNow[i] = dischargeSwitchOff;
		end else if (i == ARM_B_STACK_LOW) begin : g_src
			assign srcNow[i] = stackBelowShutdown;
		end else if (i == ARM_B_BLOW) begin : g_src
			assign srcNow[i] = blowOutputDriven;
		end else if (i == ARM_B_BALANCE) begin : g_src
			assign srcNow[i] = balancingActive;
		end else if (i == ARM_B_SCAN) begin : g_src
			assign srcNow[i] = singleScanDone | st.scanSeen;
		end else if (i == ARM_B_WAKE) begin : g_src
			assign srcNow[i] = wokeFromSleep;
		end else begin : g_src
			// the reserved position has no source and reads zero
			assign srcNow[i] = 1'b0;
		end
		// a source still enabled sets the bit again, so set beats a clear
		assign setBits[i] = srcNow[i] & st.mask[i] & ARM_VALID_BITS[i];
		assign latchNext[i] = ((st.latched[i] & ~clearBits[i]) | setBits[i]) &
			ARM_VALID_BITS[i];
	end

	// a request is taken only when idle and past the settle cycle after reset
	always_comb begin
		hit = 1'b0;
		case (address)
			ARM_OFF_RAW: begin
				hit = 1'b1;
			end
			ARM_OFF_MASK: begin
				hit = 1'b1;
			end
			ARM_OFF_LATCH: begin
				hit = 1'b1;
			end
			ARM_OFF_CTRL: begin
				hit = 1'b1;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
		acc = (read | write) & ~st.busy & (st.settle == 2'h0);
		// writes land at the edge where waitrequest is sampled low
		commit = write & st.busy;
		reloadNow = commit & (address == ARM_OFF_CTRL) & byteenable[0] &
			writedata[ARM_CTRL_RELOAD];
	end

	always_comb begin
		readMux = 32'h0000_0000;
		case (address)
			ARM_OFF_RAW: begin
				readMux = {16'h0000, st.raw};
			end
			ARM_OFF_MASK: begin
				readMux = {16'h0000, st.mask};
			end
			ARM_OFF_LATCH: begin
				readMux = {16'h0000, st.latched};
			end
			default: begin
				// control and unmapped offsets read as zero
				readMux = 32'h0000_0000;
			end
		endcase
	end

	// write-one-to-clear: only enabled lanes can clear
	always_comb begin
		clearBits = '0;
		if (commit & (address == ARM_OFF_LATCH)) begin
			if (byteenable[0]) begin
				clearBits[7:0] = writedata[7:0];
			end
			if (byteenable[1]) begin
				clearBits[15:8] = writedata[15:8];
			end
		end
	end

	// the first enabled edge after reset takes the stored default mask
	always_comb begin
		maskNext = st.mask;
		if (!st.reloaded | reloadNow) begin
			maskNext = DEFAULT_MASK & ARM_VALID_BITS;
		end else if (commit & (address == ARM_OFF_MASK)) begin
			if (byteenable[0]) begin
				maskNext[7:0] = writedata[7:0] & ARM_VALID_BITS[7:0];
			end
			if (byteenable[1]) begin
				maskNext[15:8] = writedata[15:8] & ARM_VALID_BITS[15:8];
			end
		end
	end

	always_comb begin
		next_st = st;
		// raw register follows sources whatever the mask holds
		next_st.raw = srcNow;
		next_st.fullSeen = st.fullSeen | fullLoopDone;
		next_st.scanSeen = st.scanSeen | singleScanDone;
		if (st.settle != 2'h0) begin
			next_st.settle = st.settle - 2'h1;
		end
		next_st.reloaded = 1'b1;
		next_st.mask = maskNext;
		// one-cycle answer: busy drops waitrequest for the accepting edge only
		next_st.busy = acc;
		if (acc) begin
			next_st.resp = hit ? 2'h0 : 2'h2;
			next_st.rdata = read ? readMux : 32'h0000_0000;
		end
		next_st.latched = latchNext;
		next_st.alert = |latchNext;
	end

	// a low clock enable in mid-answer loses the write; callers keep it high then
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st <= '0;
			st.settle <= ARM_SETTLE;
		end else if (clkEn) begin
			st <= next_st;
		end
	end

	// waitrequest stays high until the accepting cycle; outputs come from flops
	assign waitrequest = ~st.busy;
	assign readdata = st.rdata;
	assign response = st.resp;
	assign alert = st.alert;
	assign latchedAlarm = st.latched;
endmodule : arm_alarm_core

// ===== arm_alarm_core_assertions.sv
// port checks for the alarm core
// assumes the bus stays idle whenever clkEn is low
`timescale 1ns/1ns
module arm_alarm_checker (
	input wire logic ref_clk, // clock
	input wire logic rst, // reset
	input wire logic clkEn, // clock enable
	input wire logic [arm_pkg::ARM_AW-1:0] address, // address
	input wire logic read, // read
	input wire logic write, // write
	input wire logic waitrequest, // stall
	input wire logic [31:0] readdata, // read data
	input wire logic [1:0] response, // response
	input wire logic alert, // alert
	input wire logic [arm_pkg::ARM_W-1:0] latchedAlarm // latched
);
	import arm_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	alert_follow_a: assert property (alert == |latchedAlarm)
		else $error("alert not tied to latch");
	freeze_hold_a: assert property (!clkEn |=> $stable(latchedAlarm) && $stable(alert))
		else $error("state moved while frozen");
	bit8_zero_a: assert property (!latchedAlarm[ARM_B_RESERVED])
		else $error("reserved bit set");
	latch_hold_a: assert property (|($past(latchedAlarm) & ~latchedAlarm) |->
		$past(write && !waitrequest && address == ARM_OFF_LATCH)) else $error("latch lost");
	wait_bound_a: assert property ((read || write) && waitrequest |-> ##[1:4] !waitrequest)
		else $error("no answer");
	answer_once_a: assert property (!waitrequest |=> waitrequest) else $error("long answer");
	answer_req_a: assert property (!waitrequest |-> read || write) else $error("idle answer");
	resp_code_a: assert property (!waitrequest |->
		response == (address[1:0] != 2'h0 ? 2'h2 : 2'h0)) else $error("bad response");
	upper_zero_a: assert property (!waitrequest && read |-> readdata[31:16] == 16'h0)
		else $error("upper data set");
endmodule : arm_alarm_checker
bind arm_alarm_core arm_alarm_checker chk (.ref_clk, .rst, .clkEn, .address, .read, .write,
	.waitrequest, .readdata, .response, .alert, .latchedAlarm);

// ===== arm_host_model.sv
// host that reaches the alarm registers over Avalon-MM
// assumes waitrequest comes from a flop of the device
`timescale 1ns/1ns
module arm_host_model (
	input wire logic ref_clk, // clock
	output logic [3:0] address, // address
	output logic read, // read
	output logic write, // write
	output logic [3:0] byteenable, // lanes
	output logic [31:0] writedata, // write data
	input wire logic [31:0] readdata, // read data
	input wire logic waitrequest, // stall
	input wire logic [1:0] response // response
);
	initial begin
		{address, read, write, writedata} = '0;
		byteenable = 4'hf;
	end
	// the request stands until waitrequest is sampled low at a rising edge;
	// only the bench watchdog ends a wait that never gets an answer
	task xfer(input logic w, input logic [3:0] a, input logic [3:0] be,
		input logic [15:0] d, output logic [31:0] q, output logic [1:0] r);
		@(posedge ref_clk);
		address <= a;
		byteenable <= be;
		writedata <= {16'h0000, d};
		read <= !w;
		write <= w;
		do begin
			@(posedge ref_clk);
		end while (waitrequest !== 1'b0);
		q = readdata;
		r = response;
		read <= 1'b0;
		write <= 1'b0;
	endtask : xfer
endmodule : arm_host_model

// ===== test_alarm_raw_and_mask_logic.sv
// self-checking bench for the alarm core
// assumes the host model drives the register bus
`timescale 1ns/1ns
module test_alarm_raw_and_mask_logic;
	import arm_pkg::*;
	localparam logic [ARM_W-1:0] DMASK = 16'h0082;
	logic ref_clk = 0, rst = 1, read, write, waitrequest, alert;
	logic clkEn = 1'b1;
	logic [3:0] address, byteenable;
	logic [31:0] writedata, readdata, q;
	logic [1:0] response, r;
	logic [15:0] src = 16'h0, latchedAlarm, sticky;
	int nFail = 0, checkCount = 0;
	arm_alarm_core #(.DEFAULT_MASK(DMASK)) dut (.ref_clk, .rst, .clkEn, .address,
		.read, .write, .byteenable, .writedata, .readdata, .waitrequest, .response,
		.safetyBcAny(src[15]), .safetyAAny(src[14]), .permFailFault(src[13]),
		.safetyAlertHit(src[12]), .permFailAlertHit(src[11]), .initStarted(src[10]),
		.initCompleted(src[9]), .fullLoopDone(src[7]), .chargeSwitchOff(src[6]),
		.dischargeSwitchOff(src[5]), .stackBelowShutdown(src[4]),
		.blowOutputDriven(src[3]), .balancingActive(src[2]), .singleScanDone(src[1]),
		.wokeFromSleep(src[0]), .alert, .latchedAlarm);
	arm_host_model host (.ref_clk, .address, .read, .write, .byteenable, .writedata,
		.readdata, .waitrequest, .response);
	initial forever #5 ref_clk = ~ref_clk;
	task conclude;
		if (nFail == 0 && checkCount > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : conclude
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			nFail++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task rd(input logic [3:0] a);
		host.xfer(1'b0, a, 4'hf, 16'h0000, q, r);
	endtask : rd
	task wr(input logic [3:0] a, input logic [3:0] be, input logic [15:0] d);
		host.xfer(1'b1, a, be, d, q, r);
	endtask : wr
	task t_reset;
		rd(ARM_OFF_MASK);
		chk(q, {16'h0000, DMASK});
		rd(ARM_OFF_RAW);
		chk(q, 32'h0000_0000);
	endtask : t_reset
	// full-loop and scan pulses stay set in the raw view, so they accumulate across the walk
	task t_raw;
		sticky = 16'h0000;
		for (int k = 15; k >= 0; k--) begin
			if (k != ARM_B_RESERVED) begin
				@(posedge ref_clk);
				src <= 16'h0001 << k;
				if (k == ARM_B_FULL_LOOP || k == ARM_B_SCAN) begin
					sticky[k] = 1'b1;
				end
				repeat (2) @(posedge ref_clk);
				rd(ARM_OFF_RAW);
				chk(q, {16'h0000, (16'h0001 << k) | sticky});
				src <= 16'h0000;
			end
		end
		rd(ARM_OFF_RAW);
		chk(q, {16'h0000, sticky});
	endtask : t_raw
	task t_latch;
		wr(ARM_OFF_MASK, 4'h3, 16'hffff);
		rd(ARM_OFF_MASK);
		chk(q, 32'h0000_feff);
		src <= 16'h8000;
		@(posedge ref_clk);
		src <= 16'h0000;
		repeat (3) @(posedge ref_clk);
		rd(ARM_OFF_LATCH);
		chk(q, 32'h0000_8082);
		chk({31'h0, alert}, 32'h0000_0001);
		wr(ARM_OFF_LATCH, 4'h3, 16'h8000);
		rd(ARM_OFF_LATCH);
		chk(q, 32'h0000_0082);
		wr(ARM_OFF_MASK, 4'h3, 16'h0000);
		wr(ARM_OFF_LATCH, 4'h3, 16'hffff);
		repeat (2) @(posedge ref_clk);
		chk({31'h0, alert}, 32'h0000_0000);
		chk({16'h0000, latchedAlarm}, 32'h0000_0000);
		rd(ARM_OFF_RAW);
		chk(q, 32'h0000_0082);
		wr(ARM_OFF_CTRL, 4'h1, 16'h0001);
		rd(ARM_OFF_MASK);
		chk(q, {16'h0000, DMASK});
		rd(4'h2);
		chk({30'h0, r}, 32'h0000_0002);
	endtask : t_latch
	// a lane-1 write leaves the low mask byte alone; a low clock enable holds the latch
	task t_freeze;
		wr(ARM_OFF_MASK, 4'h2, 16'h40ff);
		rd(ARM_OFF_MASK);
		chk(q, 32'h0000_4082);
		clkEn <= 1'b0;
		src <= 16'h4000;
		repeat (3) @(posedge ref_clk);
		chk({16'h0000, latchedAlarm}, 32'h0000_0082);
		clkEn <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk({16'h0000, latchedAlarm}, 32'h0000_4082);
		chk({31'h0, alert}, 32'h0000_0001);
		src <= 16'h0000;
	endtask : t_freeze
	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset;
		t_raw;
		t_latch;
		t_freeze;
		conclude;
	end
	initial begin
		#200000;
		nFail++;
		conclude;
	end
endmodule : test_alarm_raw_and_mask_logic
